//--- inc/sfspr_consts.svh
// Constants of the serial flash status, protection and read sequencer.
// Functional notes
// - Status write changes bits seven to two only.
// - Status write ignored unless write latch set.
// - Select rising off byte boundary rejects write.
// - Self-timed write holds busy, then clears latch.
// - Disable bit plus low protect pin rejects writes.
// - Unprotected write may change disable and level bits.
// - Hardware protection when disable set, pin low, outside four-line mode.
// - Protect pin high leaves hardware protection.
// - Four-line read mode disables hardware protection.
// - Level bits guard area against program, erase; here they are only passed out on statusOut.
// - Status write sets quad enable, disable, levels.
// - Plain read samples rising, drives falling edges.
// - Address increments per byte, wraps to zero.
// - Fast read drives data after one dummy byte.
// - Busy device rejects fast and dual reads.
// - Dual read: address, dummy, data on two lines.
// - After dual opcode two bits per clock.
// - Two-bit unit carries high bit on line one.
// - Write-enable command sets the write latch.
// - Busy bit reads one during a write cycle.
`ifndef SFSPR_CONSTS_SVH
`define SFSPR_CONSTS_SVH

`define SFSPR_OP_WRITE_ENABLE  8'h06
`define SFSPR_OP_WRITE_DISABLE 8'h04
`define SFSPR_OP_STATUS_READ   8'h05
`define SFSPR_OP_STATUS_WRITE  8'h01
`define SFSPR_OP_PLAIN_READ    8'h03
`define SFSPR_OP_FAST_READ     8'h0B
`define SFSPR_OP_DUAL_READ     8'hBB

`define SFSPR_BIT_WRITE_DISABLE 7
`define SFSPR_BIT_QUAD_ENABLE   6
`define SFSPR_BIT_WRITE_LATCH   1
`define SFSPR_BIT_BUSY          0

`define SFSPR_SYNC_SCLK 4
`define SFSPR_SYNC_CS_N 3
`define SFSPR_SYNC_DL0  2
`define SFSPR_SYNC_DL1  1
`define SFSPR_SYNC_WP_N 0
// Idle pin levels: serial clock low, select and the other lines high.
`define SFSPR_SYNC_IDLE 5'h0F

`define SFSPR_ADDR_UNITS_SINGLE  5'h17
`define SFSPR_ADDR_UNITS_DUAL    5'h0B
`define SFSPR_DUMMY_UNITS_SINGLE 5'h07
`define SFSPR_DUMMY_UNITS_DUAL   5'h01
`define SFSPR_OP_LAST_BIT        5'h07
`define SFSPR_STATUS_BYTE_BITS   5'h08
`define SFSPR_COUNT_SATURATE     5'h1F

`define SFSPR_CLK_PERIOD_NS        5
`define SFSPR_STATUS_WRITE_TIME_US 40

`endif

//--- inc/sfspr_pkg.sv
// Types of the serial flash status, protection and read sequencer.
package sfspr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_DUMMY,
        ST_DATA,
        ST_WSTAT,
        ST_TAIL
    } sfspr_state_t;

    typedef struct packed {
        logic drive;
        logic oeN;
    } sfspr_line_t;

endpackage : sfspr_pkg

//--- rtl/sfspr_flash_seq.sv
// Serial flash command sequencer: status, protection and serial reads.
`timescale 1ns/10ps
`default_nettype none
`include "sfspr_consts.svh"

module sfspr_flash_seq #(
    parameter int unsigned WR_CYCLES =
        `SFSPR_STATUS_WRITE_TIME_US * 1000 / `SFSPR_CLK_PERIOD_NS
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 sclkPin,
    input  wire logic                 csPin_n,
    input  wire logic                 dl0In,
    input  wire logic                 dl1In,
    input  wire logic                 wpLine2_n,
    input  wire logic                 quadModeActive,
    input  wire logic [5:0]           nvInit,
    input  wire logic [7:0]           memData,
    output var  sfspr_pkg::sfspr_line_t dl0Drv,
    output var  sfspr_pkg::sfspr_line_t dl1Drv,
    output logic [23:0]               memAddr,
    output logic [7:0]                statusOut,
    output logic                      hwProtect
);
    import sfspr_pkg::*;

    logic [4:0]   syncA_ff;
    logic [4:0]   syncB_ff;
    logic         sclkD_ff;
    logic         csD_ff;
    sfspr_state_t state_ff,   nxt_state;
    logic [4:0]   bitCnt_ff,  nxt_bitCnt;
    logic [23:0]  inSh_ff,    nxt_inSh;
    logic [7:0]   opcode_ff,  nxt_opcode;
    logic         dual_ff,    nxt_dual;
    logic         srcStat_ff, nxt_srcStat;
    logic [23:0]  memAddr_ff, nxt_memAddr;
    logic [7:0]   outSh_ff,   nxt_outSh;
    logic [2:0]   outCnt_ff,  nxt_outCnt;
    logic [5:0]   nvBits_ff,  nxt_nvBits;
    logic         wel_ff,     nxt_wel;
    logic         busy_ff,    nxt_busy;
    logic [15:0]  timer_ff,   nxt_timer;
    sfspr_line_t  dl0_ff,     nxt_dl0;
    sfspr_line_t  dl1_ff,     nxt_dl1;
    logic         hwProt_ff,  nxt_hwProt;
    logic [7:0]   status_ff,  nxt_status;

    logic sclk;
    logic csHigh;
    logic sRise;
    logic sFall;
    logic csRise;
    logic d0;
    logic d1;
    logic hpmNow;

    assign sclk   = syncB_ff[`SFSPR_SYNC_SCLK];
    assign csHigh = syncB_ff[`SFSPR_SYNC_CS_N];
    assign d0     = syncB_ff[`SFSPR_SYNC_DL0];
    assign d1     = syncB_ff[`SFSPR_SYNC_DL1];
    assign sRise  = sclk & ~sclkD_ff;
    assign sFall  = ~sclk & sclkD_ff;
    assign csRise = csHigh & ~csD_ff;
    // Protection needs the disable bit and a low pin, in either order.
    // The pin carries data in four-line mode, so protection is off there.
    assign hpmNow = nvBits_ff[`SFSPR_BIT_WRITE_DISABLE - 2] & ~syncB_ff[`SFSPR_SYNC_WP_N]
                    & ~quadModeActive;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Synchronisers start at the idle levels so no false clock edge follows reset.
            syncA_ff <= `SFSPR_SYNC_IDLE;
            syncB_ff <= `SFSPR_SYNC_IDLE;
            sclkD_ff <= 1'b0;
            csD_ff   <= 1'b1;
        end
        else
        begin
            syncA_ff <= {sclkPin, csPin_n, dl0In, dl1In, wpLine2_n};
            syncB_ff <= syncA_ff;
            sclkD_ff <= syncB_ff[`SFSPR_SYNC_SCLK];
            csD_ff   <= syncB_ff[`SFSPR_SYNC_CS_N];
        end
    end

    always_comb
    begin
        logic [23:0] shNext;
        logic [7:0]  outByte;
        shNext      = 24'h00_0000;
        outByte     = 8'h00;
        nxt_state   = state_ff;
        nxt_bitCnt  = bitCnt_ff;
        nxt_inSh    = inSh_ff;
        nxt_opcode  = opcode_ff;
        nxt_dual    = dual_ff;
        nxt_srcStat = srcStat_ff;
        nxt_memAddr = memAddr_ff;
        nxt_outSh   = outSh_ff;
        nxt_outCnt  = outCnt_ff;
        nxt_nvBits  = nvBits_ff;
        nxt_wel     = wel_ff;
        nxt_busy    = busy_ff;
        nxt_timer   = timer_ff;
        nxt_dl0     = dl0_ff;
        nxt_dl1     = dl1_ff;

        if (busy_ff)
        begin
            nxt_timer = timer_ff - 16'h0001;
            if (timer_ff == 16'h0001)
            begin
                nxt_busy = 1'b0;
                nxt_wel  = 1'b0;
            end
        end

        if (csHigh)
        begin
            nxt_state  = ST_IDLE;
            nxt_bitCnt = 5'h00;
            nxt_outCnt = 3'h0;
            nxt_dual   = 1'b0;
            nxt_dl0    = '{drive: 1'b0, oeN: 1'b1};
            nxt_dl1    = '{drive: 1'b0, oeN: 1'b1};
            if (csRise && state_ff == ST_TAIL && bitCnt_ff == 5'h00 && !busy_ff)
            begin
                if (opcode_ff == `SFSPR_OP_WRITE_ENABLE)
                begin
                    nxt_wel = 1'b1;
                end
                else if (opcode_ff == `SFSPR_OP_WRITE_DISABLE)
                begin
                    nxt_wel = 1'b0;
                end
            end
            // Commit only on exactly one data byte, still enabled, unprotected.
            if (csRise && state_ff == ST_WSTAT && bitCnt_ff == `SFSPR_STATUS_BYTE_BITS
                && wel_ff && !hpmNow)
            begin
                nxt_nvBits = inSh_ff[7:2];
                nxt_busy   = 1'b1;
                nxt_timer  = 16'(WR_CYCLES);
            end
        end
        else
        begin
            if (state_ff == ST_IDLE)
            begin
                nxt_state = ST_CMD;
            end
            if (sRise)
            begin
                case (state_ff)
                    ST_IDLE, ST_CMD:
                    begin
                        nxt_inSh   = {inSh_ff[22:0], d0};
                        nxt_bitCnt = bitCnt_ff + 5'h01;
                        if (bitCnt_ff == `SFSPR_OP_LAST_BIT)
                        begin
                            nxt_opcode = {inSh_ff[6:0], d0};
                            nxt_bitCnt = 5'h00;
                            nxt_state  = ST_TAIL;
                            case ({inSh_ff[6:0], d0})
                                `SFSPR_OP_PLAIN_READ: nxt_state = ST_ADDR;
                                `SFSPR_OP_FAST_READ:
                                begin
                                    if (!busy_ff)
                                    begin
                                        nxt_state = ST_ADDR;
                                    end
                                end
                                `SFSPR_OP_DUAL_READ:
                                begin
                                    if (!busy_ff)
                                    begin
                                        nxt_state = ST_ADDR;
                                        nxt_dual  = 1'b1;
                                    end
                                end
                                `SFSPR_OP_STATUS_READ:
                                begin
                                    nxt_state   = ST_DATA;
                                    nxt_srcStat = 1'b1;
                                end
                                `SFSPR_OP_STATUS_WRITE:
                                begin
                                    if (wel_ff && !hpmNow && !busy_ff)
                                    begin
                                        nxt_state = ST_WSTAT;
                                    end
                                end
                                default: nxt_state = ST_TAIL;
                            endcase
                            if ({inSh_ff[6:0], d0} != `SFSPR_OP_STATUS_READ)
                            begin
                                nxt_srcStat = 1'b0;
                            end
                        end
                    end
                    ST_ADDR:
                    begin
                        // Rising-edge address; pair high bit on line one.
                        shNext     = dual_ff ? {inSh_ff[21:0], d1, d0} : {inSh_ff[22:0], d0};
                        nxt_inSh   = shNext;
                        nxt_bitCnt = bitCnt_ff + 5'h01;
                        if (bitCnt_ff == (dual_ff ? `SFSPR_ADDR_UNITS_DUAL
                                                  : `SFSPR_ADDR_UNITS_SINGLE))
                        begin
                            nxt_memAddr = shNext;
                            nxt_bitCnt  = 5'h00;
                            nxt_state   = (opcode_ff == `SFSPR_OP_PLAIN_READ) ? ST_DATA
                                                                              : ST_DUMMY;
                        end
                    end
                    ST_DUMMY:
                    begin
                        nxt_bitCnt = bitCnt_ff + 5'h01;
                        if (bitCnt_ff == (dual_ff ? `SFSPR_DUMMY_UNITS_DUAL
                                                  : `SFSPR_DUMMY_UNITS_SINGLE))
                        begin
                            nxt_bitCnt = 5'h00;
                            nxt_state  = ST_DATA;
                        end
                    end
                    ST_WSTAT, ST_TAIL:
                    begin
                        nxt_inSh = {inSh_ff[22:0], d0};
                        if (bitCnt_ff != `SFSPR_COUNT_SATURATE)
                        begin
                            nxt_bitCnt = bitCnt_ff + 5'h01;
                        end
                    end
                    ST_DATA: nxt_bitCnt = bitCnt_ff;
                    default: nxt_state = ST_IDLE;
                endcase
            end
            if (sFall && state_ff == ST_DATA)
            begin
                // Data leaves on falling edges until select rises.
                outByte = outSh_ff;
                if (outCnt_ff == 3'h0)
                begin
                    outByte = srcStat_ff ? status_ff : memData;
                    if (!srcStat_ff)
                    begin
                        nxt_memAddr = memAddr_ff + 24'h00_0001;
                    end
                end
                nxt_dl1 = '{drive: outByte[7], oeN: 1'b0};
                if (dual_ff)
                begin
                    nxt_dl0    = '{drive: outByte[6], oeN: 1'b0};
                    nxt_outSh  = {outByte[5:0], 2'b00};
                    nxt_outCnt = outCnt_ff + 3'h2;
                end
                else
                begin
                    nxt_outSh  = {outByte[6:0], 1'b0};
                    nxt_outCnt = outCnt_ff + 3'h1;
                end
            end
        end
        nxt_hwProt = hpmNow;
        nxt_status = {nxt_nvBits, nxt_wel, nxt_busy};
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff   <= ST_IDLE;
            bitCnt_ff  <= 5'h00;
            inSh_ff    <= 24'h00_0000;
            opcode_ff  <= 8'h00;
            dual_ff    <= 1'b0;
            srcStat_ff <= 1'b0;
            memAddr_ff <= 24'h00_0000;
            outSh_ff   <= 8'h00;
            outCnt_ff  <= 3'h0;
            nvBits_ff  <= nvInit;
            wel_ff     <= 1'b0;
            busy_ff    <= 1'b0;
            timer_ff   <= 16'h0000;
            dl0_ff     <= '{drive: 1'b0, oeN: 1'b1};
            dl1_ff     <= '{drive: 1'b0, oeN: 1'b1};
            hwProt_ff  <= 1'b0;
            status_ff  <= {nvInit, 2'b00};
        end
        else
        begin
            state_ff   <= nxt_state;
            bitCnt_ff  <= nxt_bitCnt;
            inSh_ff    <= nxt_inSh;
            opcode_ff  <= nxt_opcode;
            dual_ff    <= nxt_dual;
            srcStat_ff <= nxt_srcStat;
            memAddr_ff <= nxt_memAddr;
            outSh_ff   <= nxt_outSh;
            outCnt_ff  <= nxt_outCnt;
            nvBits_ff  <= nxt_nvBits;
            wel_ff     <= nxt_wel;
            busy_ff    <= nxt_busy;
            timer_ff   <= nxt_timer;
            dl0_ff     <= nxt_dl0;
            dl1_ff     <= nxt_dl1;
            hwProt_ff  <= nxt_hwProt;
            status_ff  <= nxt_status;
        end
    end

    // The level bits go out with the status so array logic can refuse writes.
    assign statusOut = status_ff;
    assign hwProtect = hwProt_ff;
    assign memAddr   = memAddr_ff;
    assign dl0Drv    = dl0_ff;
    assign dl1Drv    = dl1_ff;

endmodule : sfspr_flash_seq
`default_nettype wire

//--- dv/sfspr_flash_properties.sv
// Port checks of the serial flash sequencer, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
module sfspr_flash_properties #(
    parameter int unsigned WR_CYCLES = 8000
) (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic                   sclkPin,
    input wire logic                   csPin_n,
    input wire logic                   wpLine2_n,
    input wire logic                   quadModeActive,
    input wire logic [5:0]             nvInit,
    input wire sfspr_pkg::sfspr_line_t dl0Drv,
    input wire sfspr_pkg::sfspr_line_t dl1Drv,
    input wire logic [7:0]             statusOut,
    input wire logic                   hwProtect
);
    import sfspr_pkg::*;
    logic [31:0] busyCnt_ff;
    logic [31:0] nxt_busyCnt;
    // Counts the cycles for which busy has been shown.
    always_comb nxt_busyCnt = statusOut[0] ? busyCnt_ff + 32'h0000_0001 : 32'h0000_0000;
    always_ff @(posedge clk) busyCnt_ff <= rst_n ? nxt_busyCnt : 32'h0000_0000;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_reset_status:
        assert property (disable iff (1'b0) !rst_n |=> statusOut == {nvInit, 2'b00} && !hwProtect)
        else $error("status or protect wrong after reset");
    a_hw_enter:
        assert property ((statusOut[7] && !wpLine2_n && !quadModeActive)[*6] |-> hwProtect)
        else $error("hardware protection not entered");
    a_hw_leave:
        assert property (wpLine2_n[*6] |-> !hwProtect)
        else $error("hardware protection with protect pin high");
    a_quad_off:
        assert property (quadModeActive[*2] |-> !hwProtect)
        else $error("hardware protection in four-line mode");
    a_hw_frozen:
        assert property ((hwProtect && !wpLine2_n)[*6] |=> $stable(statusOut[7:2]))
        else $error("stored bits changed under hardware protection");
    a_commit_only:
        assert property (!$stable(statusOut[7:2]) |-> $rose(statusOut[0]))
        else $error("stored bits changed without a write cycle");
    a_busy_latch:
        assert property ($rose(statusOut[0]) |-> statusOut[1])
        else $error("write cycle started without latch");
    a_busy_end:
        assert property ($fell(statusOut[0]) |-> !statusOut[1])
        else $error("latch not cleared at end of write cycle");
    a_busy_span:
        assert property ($fell(statusOut[0]) |-> busyCnt_ff == WR_CYCLES)
        else $error("write cycle length wrong");
    a_out_still:
        assert property ((!csPin_n && sclkPin)[*6] |-> $stable(dl1Drv) && $stable(dl0Drv))
        else $error("output changed while serial clock high");
    a_lines_free:
        assert property (csPin_n[*5] |-> dl0Drv.oeN && dl1Drv.oeN)
        else $error("line driven while deselected");
    c_hw_on: cover property ($rose(hwProtect));
    c_busy_done: cover property ($fell(statusOut[0]));
    c_dual_out: cover property ($fell(dl0Drv.oeN));
endmodule : sfspr_flash_properties
bind sfspr_flash_seq sfspr_flash_properties #(.WR_CYCLES(WR_CYCLES)) i_props (
    .clk(clk), .rst_n(rst_n), .sclkPin(sclkPin), .csPin_n(csPin_n), .wpLine2_n(wpLine2_n),
    .quadModeActive(quadModeActive), .nvInit(nvInit), .dl0Drv(dl0Drv), .dl1Drv(dl1Drv),
    .statusOut(statusOut), .hwProtect(hwProtect)
);
`default_nettype wire

//--- dv/sfspr_host_model.sv
// Host controller model: drives select, serial clock and data lines in mode 0.
`timescale 1ns/10ps
`default_nettype none
module sfspr_host_model (
    input  wire logic                   clk,
    output var  logic                   sclkPin,
    output var  logic                   csPin_n,
    output var  logic                   dl0In,
    output var  logic                   dl1In,
    input  wire sfspr_pkg::sfspr_line_t dl0Drv,
    input  wire sfspr_pkg::sfspr_line_t dl1Drv
);
    import sfspr_pkg::*;
    logic       sawDrive;
    logic [1:0] lastIn;
    initial
    begin
        sclkPin  = 1'b0;
        csPin_n  = 1'b1;
        dl0In    = 1'b0;
        dl1In    = 1'b1;
        sawDrive = 1'b0;
        lastIn   = 2'b00;
    end
    // One serial clock; a released line shows the inverse of its last level.
    task automatic cyc(input logic [1:0] o, input logic [1:0] rel, output logic [1:0] i);
        dl1In <= rel[1] ? ~dl1In : o[1];
        dl0In <= rel[0] ? ~dl0In : o[0];
        repeat (8) @(posedge clk);
        i = {dl1Drv.oeN ? ~lastIn[1] : dl1Drv.drive, dl0Drv.oeN ? ~lastIn[0] : dl0Drv.drive};
        lastIn = i;
        sawDrive |= !(dl0Drv.oeN && dl1Drv.oeN);
        sclkPin <= 1'b1;
        repeat (8) @(posedge clk);
        sclkPin <= 1'b0;
    endtask : cyc
    task automatic send(input logic [7:0] v, input int n, input logic dual);
        logic [1:0] d;
        for (int k = 7; k > 7 - n; k -= dual ? 2 : 1)
            cyc(dual ? v[k -: 2] : {1'b0, v[k]}, dual ? 2'b00 : 2'b10, d);
    endtask : send
    task automatic recv(output logic [7:0] v, input logic dual);
        logic [1:0] d;
        for (int k = 0; k < (dual ? 4 : 8); k++)
        begin
            cyc(2'b00, 2'b11, d);
            v = dual ? {v[5:0], d} : {v[6:0], d[1]};
        end
    endtask : recv
    task automatic sel();
        csPin_n <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : sel
    // Select rises only after whole units, with a gap before the next frame.
    task automatic desel();
        repeat (4) @(posedge clk);
        csPin_n <= 1'b1;
        repeat (12) @(posedge clk);
    endtask : desel
endmodule : sfspr_host_model
`default_nettype wire

//--- dv/tb.sv
// Testbench of the serial flash sequencer driven through the host model.
`timescale 1ns/10ps
`default_nettype none
`include "sfspr_consts.svh"
`define CHECK_EQ(got, exp) \
    begin \
        checksDone++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module tb;
    import sfspr_pkg::*;
    localparam int unsigned WR = 1600;
    localparam logic [5:0]  NV = 6'h0B;
    logic        clk, rst_n, sclkPin, csPin_n, dl0In, dl1In, wpLine2_n, quadModeActive;
    logic        hwProtect;
    logic [7:0]  memData, statusOut, rv;
    logic [23:0] memAddr;
    sfspr_line_t dl0Drv, dl1Drv;
    int          miscompares, checksDone;
    function automatic logic [7:0] pat(input logic [23:0] a);
        return a[23:16] ^ a[7:0] ^ 8'hA5;
    endfunction : pat
    assign memData = pat(memAddr);
    sfspr_flash_seq #(.WR_CYCLES(WR)) i_dut (
        .clk(clk), .rst_n(rst_n), .sclkPin(sclkPin), .csPin_n(csPin_n), .dl0In(dl0In),
        .dl1In(dl1In), .wpLine2_n(wpLine2_n), .quadModeActive(quadModeActive), .nvInit(NV),
        .memData(memData), .dl0Drv(dl0Drv), .dl1Drv(dl1Drv), .memAddr(memAddr),
        .statusOut(statusOut), .hwProtect(hwProtect));
    sfspr_host_model host (
        .clk(clk), .sclkPin(sclkPin), .csPin_n(csPin_n), .dl0In(dl0In), .dl1In(dl1In),
        .dl0Drv(dl0Drv), .dl1Drv(dl1Drv));
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic cmd(input logic [7:0] op);
        host.sel();
        host.send(op, 8, 1'b0);
        host.desel();
    endtask : cmd
    task automatic swr(input logic [7:0] d, input int n);
        host.sel();
        host.send(`SFSPR_OP_STATUS_WRITE, 8, 1'b0);
        host.send(d, n, 1'b0);
        host.desel();
    endtask : swr
    task automatic rdMem(input logic [7:0] op, input logic [23:0] a, input logic dual,
                         input int dum, input int n, input logic chk);
        logic [7:0] v;
        host.sel();
        host.send(op, 8, 1'b0);
        for (int k = 2; k >= 0; k--)
            host.send(a[k*8 +: 8], 8, dual);
        host.send(8'h00, dum, dual);
        for (int k = 0; k < n; k++)
        begin
            host.recv(v, dual);
            if (chk)
                `CHECK_EQ(v, pat(a + 24'(k)))
        end
        host.desel();
    endtask : rdMem
    task automatic waitIdle();
        for (int k = 0; k < 3000 && statusOut[0] !== 1'b0; k++)
            @(posedge clk);
        `CHECK_EQ(statusOut[0], 1'b0)
    endtask : waitIdle
    initial
    begin
        rst_n          = 1'b0;
        wpLine2_n      = 1'b0;
        quadModeActive = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHECK_EQ(statusOut, {NV, 2'b00})
        swr(8'h5E, 8);
        `CHECK_EQ(statusOut, {NV, 2'b00})
        cmd(`SFSPR_OP_WRITE_ENABLE);
        `CHECK_EQ(statusOut, {NV, 2'b10})
        swr(8'h5E, 7);
        `CHECK_EQ(statusOut, {NV, 2'b10})
        swr(8'h5E, 8);
        `CHECK_EQ(statusOut, 8'h5F)
        host.sawDrive = 1'b0;
        rdMem(`SFSPR_OP_FAST_READ, 24'h00_0010, 1'b0, 8, 1, 1'b0);
        rdMem(`SFSPR_OP_DUAL_READ, 24'h00_0010, 1'b1, 4, 1, 1'b0);
        `CHECK_EQ(host.sawDrive, 1'b0)
        `CHECK_EQ(statusOut, 8'h5F)
        waitIdle();
        `CHECK_EQ(statusOut, 8'h5C)
        cmd(`SFSPR_OP_WRITE_ENABLE);
        swr(8'hA0, 8);
        waitIdle();
        repeat (2) @(posedge clk);
        `CHECK_EQ(statusOut, 8'hA0)
        `CHECK_EQ(hwProtect, 1'b1)
        cmd(`SFSPR_OP_WRITE_ENABLE);
        swr(8'h00, 8);
        `CHECK_EQ(statusOut, 8'hA2)
        quadModeActive <= 1'b1;
        repeat (4) @(posedge clk);
        `CHECK_EQ(hwProtect, 1'b0)
        quadModeActive <= 1'b0;
        wpLine2_n      <= 1'b1;
        repeat (8) @(posedge clk);
        `CHECK_EQ(hwProtect, 1'b0)
        wpLine2_n <= 1'b0;
        repeat (8) @(posedge clk);
        `CHECK_EQ(hwProtect, 1'b1)
        wpLine2_n <= 1'b1;
        repeat (8) @(posedge clk);
        swr(8'h00, 8);
        host.sel();
        host.send(`SFSPR_OP_STATUS_READ, 8, 1'b0);
        host.recv(rv, 1'b0);
        host.desel();
        `CHECK_EQ(rv, 8'h03)
        waitIdle();
        `CHECK_EQ(statusOut, 8'h00)
        cmd(`SFSPR_OP_WRITE_ENABLE);
        cmd(`SFSPR_OP_WRITE_DISABLE);
        `CHECK_EQ(statusOut, 8'h00)
        rdMem(`SFSPR_OP_PLAIN_READ, 24'hFF_FFFE, 1'b0, 0, 3, 1'b1);
        rdMem(`SFSPR_OP_FAST_READ, 24'h00_0010, 1'b0, 8, 2, 1'b1);
        rdMem(`SFSPR_OP_DUAL_READ, 24'h12_3456, 1'b1, 4, 2, 1'b1);
        stop_test();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule : tb
`default_nettype wire
